// *** hw/hold_timer.sv ***
// counts milliseconds while a condition holds, reports when limit reached
`timescale 1ns/100ps
module hold_timer import steer_pkg::*; (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // control
   input wire logic ms_tick,
   input wire logic hold,
   input wire logic [15:0] limit,
   // result
   output logic expired
);
   logic [15:0] cnt_q;

   // drops the same cycle the condition breaks
   assign expired = hold && (cnt_q >= limit);

   always_ff @(posedge sys_clk) begin
      if (reset || !hold) begin
         cnt_q <= '0;
      end else if (ms_tick && cnt_q != 16'hFFFF) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end
endmodule

// *** hw/pulse_divider.sv ***
// divides an enable stream into one pulse per DIV steps
`timescale 1ns/100ps
module pulse_divider import steer_pkg::*; #(
   parameter int DIV = 40
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // control
   input wire logic run,
   input wire logic step,
   // result
   output logic pulse
);
   localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   logic [W-1:0] cnt_q;

   assign pulse = run && step && (cnt_q == LAST);

   always_ff @(posedge sys_clk) begin
      if (reset || !run) begin
         cnt_q <= '0;
      end else if (step) begin
         cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
      end
   end
endmodule

// *** hw/steer_position_ctrl.sv ***
// closed-loop steering actuator position controller with avalon slave
//
// Function
// - curve breakpoint at 500, lock times (20-linearity)/40 per side.
// - feed-forward from wheel speed scaled by stroke volume, default 600.
// - position loop is proportional only, on set point minus position.
// - error times gain 0..200, default 50, in 0.01%/0.1% units.
// - proportional band grows with wheel speed from offset, default 100.
// - flow command clipped to max flow 0..1000, default 1000.
// - drift error times drift gain requests sensitivity change; zero disables.
// - sensitivity change limited to 0..20 percent, default 10.
// - wheel sensor position zero is the straight-ahead reference.
// - small flow for neutral timeout returns spool to neutral.
// - spool reactivates once flow command exceeds threshold.
// - steady-state threshold 0..100, tenths of percent of max flow.
// - neutral timeout 1..30000 ms.
// - zero flow request for off delay disables solenoid bridge.
// - non-zero flow request enables bridge immediately.
// - off delay of 30000 ms keeps bridge always enabled.
// - status set 2 requested streams status every 40 ms.
// - set point bounded by end locks; swapped signs reverse steering.
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
module steer_position_ctrl import steer_pkg::*; #(
   parameter int TICK_DIV = TICK_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // avalon-mm slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // sensors and set point, signed
   input wire logic [15:0] set_point,
   input wire logic [15:0] act_pos,
   input wire logic [15:0] wheel_pos,
   input wire logic [15:0] wheel_speed,
   // valve side
   output logic [15:0] port_flow,
   output logic spool_active,
   output logic bridge_enable,
   output logic [15:0] sensitivity,
   // status stream
   output logic status_valid,
   output logic [15:0] status_flow
);
   function automatic logic signed [31:0] sx(input logic [15:0] v);
      return {{16{v[15]}}, v};
   endfunction

   function automatic logic signed [31:0] sat(
      input logic signed [31:0] v,
      input logic signed [31:0] lim
   );
      if (v > lim) return lim;
      if (v < -lim) return -lim;
      return v;
   endfunction

   function automatic logic signed [31:0] mag(input logic signed [31:0] v);
      return (v < 0) ? -v : v;
   endfunction

   // configuration registers
   logic [15:0] right_end_lock_q, left_end_lock_q, curve_linearity_q;
   logic [15:0] stroke_volume_q, proportional_gain_q, max_port_flow_q;
   logic [15:0] band_offset_q, drift_gain_q, drift_change_limit_q;
   logic [15:0] neutral_timeout_q, steady_threshold_q, sol_off_delay_q;
   logic [15:0] base_sens_q;
   logic [7:0] status_stream_request_q;
   logic [31:0] readdata_q;
   logic waitrequest_q;
   logic [15:0] port_flow_q, sensitivity_q, status_flow_q;
   logic spool_active_q, bridge_enable_q, status_valid_q;

   logic ms_tick, status_tick, neutral_expired, sol_expired, cfg_ok;
   logic wr_take;
   logic [31:0] rd_mux;

   // one access per request; the answer edge drops waitrequest
   assign wr_take = write && !read && !waitrequest_q;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         waitrequest_q <= 1'b1;
      end else begin
         waitrequest_q <= !((read || write) && waitrequest_q);
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (address)
         OFS_RIGHT_LOCK: rd_mux = sx(right_end_lock_q);
         OFS_LEFT_LOCK: rd_mux = sx(left_end_lock_q);
         OFS_LINEARITY: rd_mux = sx(curve_linearity_q);
         OFS_STROKE: rd_mux = {16'h0000, stroke_volume_q};
         OFS_PGAIN: rd_mux = {16'h0000, proportional_gain_q};
         OFS_MAX_FLOW: rd_mux = {16'h0000, max_port_flow_q};
         OFS_BAND_OFS: rd_mux = {16'h0000, band_offset_q};
         OFS_DRIFT_GAIN: rd_mux = {16'h0000, drift_gain_q};
         OFS_DRIFT_LIM: rd_mux = {16'h0000, drift_change_limit_q};
         OFS_NEUTRAL_TO: rd_mux = {16'h0000, neutral_timeout_q};
         OFS_STEADY_THR: rd_mux = {16'h0000, steady_threshold_q};
         OFS_SOL_DELAY: rd_mux = {16'h0000, sol_off_delay_q};
         OFS_BASE_SENS: rd_mux = {16'h0000, base_sens_q};
         OFS_STATUS_CTL: rd_mux = {24'h00_0000, status_stream_request_q};
         OFS_STATE:
            rd_mux = {29'h0000_0000, bridge_enable_q, spool_active_q, cfg_ok};
         OFS_FLOW: rd_mux = sx(port_flow_q);
         OFS_SENS: rd_mux = {16'h0000, sensitivity_q};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         readdata_q <= 32'h0000_0000;
      end else if (read && waitrequest_q) begin
         readdata_q <= rd_mux;
      end
   end

   // register writes; unmapped offsets are ignored
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         right_end_lock_q <= RST_RIGHT_LOCK;
         left_end_lock_q <= RST_LEFT_LOCK;
         curve_linearity_q <= RST_LINEARITY;
         stroke_volume_q <= RST_STROKE;
         proportional_gain_q <= RST_PGAIN;
         max_port_flow_q <= RST_MAX_FLOW;
         band_offset_q <= RST_BAND_OFS;
         drift_gain_q <= RST_DRIFT_GAIN;
         drift_change_limit_q <= RST_DRIFT_LIM;
         neutral_timeout_q <= RST_NEUTRAL_TO;
         steady_threshold_q <= RST_STEADY_THR;
         sol_off_delay_q <= RST_SOL_DELAY;
         base_sens_q <= RST_BASE_SENS;
         status_stream_request_q <= RST_STATUS_CTL;
      end else if (wr_take) begin
         case (address)
            OFS_RIGHT_LOCK: right_end_lock_q <= writedata[15:0];
            OFS_LEFT_LOCK: left_end_lock_q <= writedata[15:0];
            OFS_LINEARITY: curve_linearity_q <= writedata[15:0];
            OFS_STROKE: stroke_volume_q <= writedata[15:0];
            OFS_PGAIN: proportional_gain_q <= writedata[15:0];
            OFS_MAX_FLOW: max_port_flow_q <= writedata[15:0];
            OFS_BAND_OFS: band_offset_q <= writedata[15:0];
            OFS_DRIFT_GAIN: drift_gain_q <= writedata[15:0];
            OFS_DRIFT_LIM: drift_change_limit_q <= writedata[15:0];
            OFS_NEUTRAL_TO: neutral_timeout_q <= writedata[15:0];
            OFS_STEADY_THR: steady_threshold_q <= writedata[15:0];
            OFS_SOL_DELAY: sol_off_delay_q <= writedata[15:0];
            OFS_BASE_SENS: base_sens_q <= writedata[15:0];
            OFS_STATUS_CTL: status_stream_request_q <= writedata[7:0];
            default: ;
         endcase
      end
   end

   // control tick
   pulse_divider #(.DIV(TICK_DIV)) u_ms_tick (
      .sys_clk(sys_clk),
      .reset(reset),
      .run(1'b1),
      .step(1'b1),
      .pulse(ms_tick)
   );

   // datapath, evaluated every cycle and sampled on the tick
   logic signed [31:0] rlock, llock, lin, x, ax, lock, bp, tgt;
   logic signed [31:0] lo, hi, ff, err, pterm, band, flow_d;
   logic signed [31:0] drift_err, drift_req, drift_lim, sens_d;

   always_comb begin
      rlock = sx(right_end_lock_q);
      llock = sx(left_end_lock_q);
      lin = sx(curve_linearity_q);
      // end locks in range, nonzero pair, opposite signs
      cfg_ok = (mag(rlock) <= FULL_SCALE) && (mag(llock) <= FULL_SCALE)
         && !(rlock == 0 && llock == 0)
         && ((rlock > 0 && llock < 0) || (rlock < 0 && llock > 0));
      x = sat(sx(set_point), FULL_SCALE);
      ax = mag(x);
      // each side bends at its own breakpoint
      lock = (x >= 0) ? rlock : llock;
      bp = lock * (CURVE_LIN_BASE - lin) / CURVE_DIV;
      if (ax <= CURVE_BREAK) begin
         tgt = ax * bp / CURVE_BREAK;
      end else begin
         tgt = bp + (ax - CURVE_BREAK) * (lock - bp) / CURVE_BREAK;
      end
      // bounded by the locks in whichever orientation they are set
      lo = (rlock < llock) ? rlock : llock;
      hi = (rlock < llock) ? llock : rlock;
      if (tgt < lo) tgt = lo;
      if (tgt > hi) tgt = hi;
      // zero stroke volume would divide by zero
      if (stroke_volume_q == 16'h0000) begin
         ff = 32'sh0000_0000;
      end else begin
         ff = sx(wheel_speed) * FF_SCALE / sx(stroke_volume_q);
      end
      err = tgt - sx(act_pos);
      pterm = err * sx(proportional_gain_q) / KP_DIV;
      band = sx(band_offset_q) + mag(ff);
      if (band > sx(max_port_flow_q)) band = sx(max_port_flow_q);
      flow_d = sat(ff + sat(pterm, band), sx(max_port_flow_q));
      // drift relative to straight-ahead sensor zero
      drift_err = sx(wheel_pos) - sx(act_pos);
      drift_req = drift_err * sx(drift_gain_q) / DRIFT_DIV;
      drift_lim = sx(base_sens_q) * sx(drift_change_limit_q) / PERCENT;
      sens_d = sx(base_sens_q) - sat(drift_req, drift_lim);
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         port_flow_q <= 16'h0000;
         sensitivity_q <= RST_BASE_SENS;
      end else if (ms_tick) begin
         port_flow_q <= flow_d[15:0];
         sensitivity_q <= sens_d[15:0];
      end
   end

   // spool neutral after sustained small command
   logic small_flow;
   assign small_flow = mag(sx(port_flow_q)) <= sx(steady_threshold_q);

   hold_timer u_neutral (
      .sys_clk(sys_clk),
      .reset(reset),
      .ms_tick(ms_tick),
      .hold(small_flow),
      .limit(neutral_timeout_q),
      .expired(neutral_expired)
   );

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         spool_active_q <= 1'b1;
      end else begin
         // timer clears as soon as the threshold is exceeded
         spool_active_q <= !neutral_expired;
      end
   end

   // solenoid bridge switch-off
   logic zero_flow;
   assign zero_flow = (port_flow_q == 16'h0000);

   hold_timer u_solenoid (
      .sys_clk(sys_clk),
      .reset(reset),
      .ms_tick(ms_tick),
      .hold(zero_flow),
      .limit(sol_off_delay_q),
      .expired(sol_expired)
   );

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         bridge_enable_q <= 1'b1;
      end else if (sol_off_delay_q == SOL_OFF_DISABLED) begin
         bridge_enable_q <= 1'b1;
      end else if (!zero_flow) begin
         bridge_enable_q <= 1'b1;
      end else begin
         bridge_enable_q <= !sol_expired;
      end
   end

   // periodic status stream
   logic stream_run;
   assign stream_run = status_stream_request_q[STC_START_BIT]
      && status_stream_request_q[STC_SET_LSB +: 4] == STATUS_SET_FLOW;

   pulse_divider #(.DIV(STATUS_PERIOD_MS)) u_status (
      .sys_clk(sys_clk),
      .reset(reset),
      .run(stream_run),
      .step(ms_tick),
      .pulse(status_tick)
   );

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         status_valid_q <= 1'b0;
         status_flow_q <= 16'h0000;
      end else begin
         status_valid_q <= status_tick;
         if (status_tick) status_flow_q <= port_flow_q;
      end
   end

   assign readdata = readdata_q;
   assign waitrequest = waitrequest_q;
   assign port_flow = port_flow_q;
   assign spool_active = spool_active_q;
   assign bridge_enable = bridge_enable_q;
   assign sensitivity = sensitivity_q;
   assign status_valid = status_valid_q;
   assign status_flow = status_flow_q;
endmodule

// *** pkg/steer_pkg.sv ***
// constants for the closed-loop steering position controller
package steer_pkg;
   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int STATUS_PERIOD_MS = 40;
   localparam logic [15:0] SOL_OFF_DISABLED = 16'h7530;
   localparam logic [3:0] STATUS_SET_FLOW = 4'h2;
   // scaling
   localparam logic signed [31:0] FULL_SCALE = 32'sh0000_03E8;
   localparam logic signed [31:0] CURVE_BREAK = 32'sh0000_01F4;
   localparam logic signed [31:0] CURVE_LIN_BASE = 32'sh0000_0014;
   localparam logic signed [31:0] CURVE_DIV = 32'sh0000_0028;
   localparam logic signed [31:0] FF_SCALE = 32'sh0000_0258;
   localparam logic signed [31:0] KP_DIV = 32'sh0000_000A;
   localparam logic signed [31:0] DRIFT_DIV = 32'sh0000_0064;
   localparam logic signed [31:0] PERCENT = 32'sh0000_0064;
   // register byte offsets
   localparam logic [7:0] OFS_RIGHT_LOCK = 8'h00;
   localparam logic [7:0] OFS_LEFT_LOCK = 8'h04;
   localparam logic [7:0] OFS_LINEARITY = 8'h08;
   localparam logic [7:0] OFS_STROKE = 8'h0C;
   localparam logic [7:0] OFS_PGAIN = 8'h10;
   localparam logic [7:0] OFS_MAX_FLOW = 8'h14;
   localparam logic [7:0] OFS_BAND_OFS = 8'h18;
   localparam logic [7:0] OFS_DRIFT_GAIN = 8'h1C;
   localparam logic [7:0] OFS_DRIFT_LIM = 8'h20;
   localparam logic [7:0] OFS_NEUTRAL_TO = 8'h24;
   localparam logic [7:0] OFS_STEADY_THR = 8'h28;
   localparam logic [7:0] OFS_SOL_DELAY = 8'h2C;
   localparam logic [7:0] OFS_BASE_SENS = 8'h30;
   localparam logic [7:0] OFS_STATUS_CTL = 8'h34;
   localparam logic [7:0] OFS_STATE = 8'h38;
   localparam logic [7:0] OFS_FLOW = 8'h3C;
   localparam logic [7:0] OFS_SENS = 8'h40;
   // status control fields
   localparam int STC_START_BIT = 0;
   localparam int STC_SET_LSB = 4;
   // reset values
   localparam logic [15:0] RST_RIGHT_LOCK = 16'h03E8;
   localparam logic [15:0] RST_LEFT_LOCK = 16'hFC18;
   localparam logic [15:0] RST_LINEARITY = 16'h0000;
   localparam logic [15:0] RST_STROKE = 16'h0258;
   localparam logic [15:0] RST_PGAIN = 16'h0032;
   localparam logic [15:0] RST_MAX_FLOW = 16'h03E8;
   localparam logic [15:0] RST_BAND_OFS = 16'h0064;
   localparam logic [15:0] RST_DRIFT_GAIN = 16'h0000;
   localparam logic [15:0] RST_DRIFT_LIM = 16'h000A;
   localparam logic [15:0] RST_NEUTRAL_TO = 16'h0BB8;
   localparam logic [15:0] RST_STEADY_THR = 16'h0032;
   localparam logic [15:0] RST_SOL_DELAY = 16'h7530;
   localparam logic [15:0] RST_BASE_SENS = 16'h0190;
   localparam logic [7:0] RST_STATUS_CTL = 8'h00;
endpackage

// *** test/sensor_model.sv ***
// actuator and wheel position sensors, held where the bench puts them
`timescale 1ns/100ps
module sensor_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // placement from bench
   input wire logic load,
   input wire logic [15:0] load_act,
   input wire logic [15:0] load_wheel,
   // sensor readings
   output logic [15:0] act_pos,
   output logic [15:0] wheel_pos
);
   // no motion model: fixed positions keep expected flow exact
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         act_pos <= 16'h0000;
         wheel_pos <= 16'h0000;
      end else if (load) begin
         act_pos <= load_act;
         wheel_pos <= load_wheel;
      end
   end
endmodule

// *** test/steer_ctrl_props.sv ***
// assertions for the steering position controller ports
`timescale 1ns/100ps
module steer_ctrl_props #(
   parameter int TICK_DIV = 20
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // register bus
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   // valve side
   input wire logic [15:0] port_flow,
   input wire logic spool_active,
   input wire logic bridge_enable,
   // status stream
   input wire logic status_valid,
   input wire logic [15:0] status_flow
);
   int gap_q;
   logic seen_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // gap only judged after a first pulse, the stream phase is free
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         gap_q <= 0;
         seen_q <= 1'b0;
      end else begin
         gap_q <= status_valid ? 0 : gap_q + 1;
         seen_q <= seen_q | status_valid;
      end
   end
   a_wait_answer: assert property ((read || write) && waitrequest |=>
      !waitrequest) else $error("bus answer not after one cycle");
   a_wait_single: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_wait_idle: assert property (!read && !write && waitrequest |=>
      waitrequest) else $error("answer without request");
   a_flow_clip: assert property ($signed(port_flow) <= 1000 &&
      $signed(port_flow) >= -1000) else $error("flow beyond full scale");
   a_flow_tick: assert property ($changed(port_flow) |=>
      $stable(port_flow)[*8]) else $error("flow changed between ticks");
   a_bridge_wake: assert property (port_flow != 16'h0000 |->
      ##[0:1] bridge_enable) else $error("bridge off with flow");
   a_bridge_off: assert property ($fell(bridge_enable) |->
      $past(port_flow) == 16'h0000) else $error("bridge off while flowing");
   a_spool_wake: assert property (($signed(port_flow) > 100 ||
      $signed(port_flow) < -100) |-> ##[0:1] spool_active)
      else $error("spool stays neutral on large flow");
   a_status_pulse: assert property (status_valid |=> !status_valid)
      else $error("status pulse longer than one cycle");
   a_status_data: assert property (status_valid |->
      status_flow == $past(port_flow)) else $error("status flow mismatch");
   a_status_gap: assert property (status_valid && seen_q |->
      gap_q == 40 * TICK_DIV - 1) else $error("status period wrong");
   c_read: cover property (read && !waitrequest);
   c_neutral: cover property ($fell(spool_active));
   c_bridge: cover property ($fell(bridge_enable));
   c_status: cover property (status_valid && seen_q);
endmodule
bind steer_position_ctrl steer_ctrl_props #(.TICK_DIV(TICK_DIV)) u_props (
   .sys_clk(sys_clk), .reset(reset), .read(read), .write(write),
   .waitrequest(waitrequest), .port_flow(port_flow),
   .spool_active(spool_active), .bridge_enable(bridge_enable),
   .status_valid(status_valid), .status_flow(status_flow));

// *** test/testbench.sv ***
// self-checking bench for the steering position controller
`timescale 1ns/100ps
module testbench import steer_pkg::*;;
   localparam int TD = 20;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest, spool_active, bridge_enable, status_valid;
   logic [15:0] set_point = 16'h0000;
   logic [15:0] wheel_speed = 16'h0000;
   logic [15:0] act_pos, wheel_pos, port_flow, sensitivity, status_flow;
   logic load = 1'b0;
   logic [15:0] load_act = 16'h0000;
   logic [15:0] load_wheel = 16'h0000;
   logic probe = 1'b0;
   logic [31:0] rq[$];
   logic [33:0] pq[$];
   logic [15:0] sq[$];
   int err_total = 0;
   int cmp_count = 0;
   int seed = 32'hAEEF66AA;
   int gain = 50, stroke = 600, flow_max = 1000, band_ofs = 100;
   int kd = 0, klim = 10, rl = 1000, ll = -1000, lin = 0, lastf = 0, n, k;
   logic [31:0] rv [18] = '{32'h3E8, 32'hFFFFFC18, 32'h0, 32'h258, 32'h32,
      32'h3E8, 32'h64, 32'h0, 32'hA, 32'hBB8, 32'h32, 32'h7530, 32'h190,
      32'h0, 32'h7, 32'h0, 32'h190, 32'h0};
   always #25 sys_clk = ~sys_clk;
   steer_position_ctrl #(.TICK_DIV(TD)) DUT (.sys_clk(sys_clk),
      .reset(reset), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .set_point(set_point), .act_pos(act_pos),
      .wheel_pos(wheel_pos), .wheel_speed(wheel_speed),
      .port_flow(port_flow), .spool_active(spool_active),
      .bridge_enable(bridge_enable), .sensitivity(sensitivity),
      .status_valid(status_valid), .status_flow(status_flow));
   sensor_model sens (.sys_clk(sys_clk), .reset(reset), .load(load),
      .load_act(load_act), .load_wheel(load_wheel), .act_pos(act_pos),
      .wheel_pos(wheel_pos));
   task automatic wrap_up();
      if (err_total == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [33:0] e, g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   function automatic int rnd(int lo, int hi);
      int r;
      r = $random(seed);
      return lo + ((r & 32'h7FFFFFFF) % (hi - lo + 1));
   endfunction
   function automatic int sat(int v, int l);
      return v > l ? l : (v < -l ? -l : v);
   endfunction
   // two straight segments per side, bent at the breakpoint
   function automatic int exp_tgt(int sp);
      int l, b, a;
      l = sp >= 0 ? rl : ll;
      b = l * (20 - lin) / 40;
      a = sp < 0 ? -sp : sp;
      return a <= 500 ? a * b / 500 : b + (a - 500) * (l - b) / 500;
   endfunction
   function automatic int exp_flow(int sp, int ap, int ws);
      int ff, b;
      ff = ws * 600 / stroke;
      b = band_ofs + (ff < 0 ? -ff : ff);
      return sat(ff + sat((exp_tgt(sp) - ap) * gain / 10,
         b > flow_max ? flow_max : b), flow_max);
   endfunction
   // holds the request until the edge that samples waitrequest low
   task automatic bus(input logic w, input logic [7:0] a, input int d);
      int t;
      t = 0;
      address <= a;
      writedata <= d;
      write <= w;
      read <= !w;
      do begin
         @(posedge sys_clk);
         t++;
      end while (waitrequest !== 1'b0 && t < 50);
      write <= 1'b0;
      read <= 1'b0;
      if (t >= 50) begin
         err_total++;
         wrap_up();
      end
      @(posedge sys_clk);
   endtask
   task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      bus(1'b0, a, 0);
   endtask
   task automatic apply(input int sp, ap, wp, ws, input logic s_e, b_e,
         input int nt);
      int c;
      set_point <= 16'(sp);
      wheel_speed <= 16'(ws);
      load <= 1'b1;
      load_act <= 16'(ap);
      load_wheel <= 16'(wp);
      @(posedge sys_clk);
      load <= 1'b0;
      repeat (nt * TD) @(posedge sys_clk);
      lastf = exp_flow(sp, ap, ws);
      c = 400 - sat((wp - ap) * kd / 100, 400 * klim / 100);
      pq.push_back({16'(lastf), 16'(c), s_e, b_e});
      probe <= 1'b1;
      @(posedge sys_clk);
      probe <= 1'b0;
      @(posedge sys_clk);
   endtask
   // scoreboard: oldest note against each result as it shows
   always @(posedge sys_clk) begin
      if (read && waitrequest === 1'b0 && rq.size() > 0)
         chk("readdata", {2'b00, rq.pop_front()}, {2'b00, readdata});
      if (probe && pq.size() > 0)
         chk("outputs", pq.pop_front(),
            {port_flow, sensitivity, spool_active, bridge_enable});
      if (status_valid === 1'b1 && sq.size() > 0)
         chk("status_flow", {18'h0, sq.pop_front()}, {18'h0, status_flow});
   end
   initial begin
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      for (int i = 0; i < 18; i++)
         bus_rd(8'(4 * i), rv[i]);
      gain = rnd(0, 200);
      bus(1'b1, OFS_PGAIN, gain);
      bus_rd(OFS_PGAIN, gain);
      bus(1'b1, 8'h44, 32'h1234);
      bus_rd(8'h44, 32'h0);
      bus(1'b1, OFS_FLOW, 32'h55);
      bus_rd(OFS_FLOW, 32'h0);
      for (int i = 0; i < 6; i++) begin
         stroke = rnd(10, 8000);
         flow_max = rnd(0, 1000);
         band_ofs = rnd(0, 1000);
         bus(1'b1, OFS_STROKE, stroke);
         bus(1'b1, OFS_MAX_FLOW, flow_max);
         bus(1'b1, OFS_BAND_OFS, band_ofs);
         apply(rnd(-1000, 1000), rnd(-1000, 1000), 0, rnd(-300, 300),
            1'b1, 1'b1, 3);
      end
      stroke = 600;
      flow_max = 1000;
      band_ofs = 100;
      bus(1'b1, OFS_STROKE, stroke);
      bus(1'b1, OFS_MAX_FLOW, flow_max);
      bus(1'b1, OFS_BAND_OFS, band_ofs);
      kd = rnd(1, 200);
      klim = rnd(0, 20);
      bus(1'b1, OFS_DRIFT_GAIN, kd);
      bus(1'b1, OFS_DRIFT_LIM, klim);
      apply(0, 0, rnd(-1000, 1000), 0, 1'b1, 1'b1, 3);
      apply(300, 300, 0, 0, 1'b1, 1'b1, 3);
      gain = 100;
      bus(1'b1, OFS_PGAIN, gain);
      bus(1'b1, OFS_NEUTRAL_TO, 4);
      bus(1'b1, OFS_STEADY_THR, 50);
      // error of 5 lands exactly on the threshold of 50
      apply(105, 100, 100, 0, 1'b0, 1'b1, 8);
      apply(106, 100, 100, 0, 1'b1, 1'b1, 2);
      bus(1'b1, OFS_SOL_DELAY, 5);
      apply(100, 100, 100, 0, 1'b0, 1'b0, 9);
      apply(200, 100, 100, 0, 1'b1, 1'b1, 2);
      // swapped locks, still opposite signs and non-zero
      bus(1'b1, OFS_RIGHT_LOCK, 32'hFFFFFC18);
      bus(1'b1, OFS_LEFT_LOCK, 32'h3E8);
      rl = -1000;
      ll = 1000;
      apply(30, 100, 100, 0, 1'b1, 1'b1, 2);
      // bent curve: errors small enough to stay inside the band
      lin = 4;
      bus(1'b1, OFS_LINEARITY, lin);
      apply(-300, 250, 100, 0, 1'b1, 1'b1, 2);
      apply(700, -650, 100, 0, 1'b1, 1'b1, 2);
      sq.push_back(16'(lastf));
      sq.push_back(16'(lastf));
      bus(1'b1, OFS_STATUS_CTL, 32'h21);
      n = 0;
      k = 0;
      while (k < 2 && n < 2000) begin
         @(posedge sys_clk);
         n++;
         if (status_valid === 1'b1)
            k++;
      end
      // let the scoreboard take its last note first
      @(posedge sys_clk);
      if (k < 2 || rq.size() + pq.size() + sq.size() != 0)
         err_total++;
      wrap_up();
   end
endmodule
